// *** core/ucq_pkg.sv ***
// Shared constants for the undervoltage cycle qualifier
package ucq_pkg;
    localparam int QUAL_WIDTH = 3;
    localparam logic [2:0] QUAL_COUNT = 3'h7;
    localparam logic [2:0] QUAL_ZERO = 3'h0;
    localparam logic [2:0] QUAL_ONE = 3'h1;
    typedef enum logic [1:0] {ST_LOCKED, ST_RUNNING} ucq_state_t;
endpackage

// *** core/ucq_edge_select.sv ***
// Master clock edge source selection: oscillator or external sync falling edge
`timescale 1ns/1ns
`default_nettype none
module ucq_edge_select (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Edge sources
    input wire logic oscTick,
    input wire logic syncIn,
    // Selected cycle start
    output logic cycleStart
);
    logic syncPrev_r;
    logic syncSeen_r;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncPrev_r <= 1'b0;
        end else begin
            syncPrev_r <= syncIn;
        end
    end

    // Any sync activity hands the master clock over; held low returns to oscillator
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            syncSeen_r <= 1'b0;
        end else if (syncIn) begin
            syncSeen_r <= 1'b1;
        end else if (!syncPrev_r) begin
            syncSeen_r <= syncSeen_r && oscTick ? 1'b0 : syncSeen_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cycleStart <= 1'b0;
        end else if (syncSeen_r) begin
            cycleStart <= syncPrev_r && !syncIn; // [R9]
        end else begin
            cycleStart <= oscTick; // [R9]
        end
    end
endmodule
`default_nettype wire

// *** core/undervoltage_cycle_qualifier.sv ***
// Per-cycle ramp qualification and undervoltage lockout state
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [R1] Each master clock edge starts a ramp
// [R2] Clock before ramp done marks undervoltage cycle
// [R3] PWM held off without ramp completion each cycle
// [R4] Three-bit counter filters per-cycle results
// [R5] Seven good cycles: power-good, soft-start, drives on
// [R6] Running: seven bad cycles declare undervoltage
// [R7] Soft-start held low while locked out
// [R8] Counter cleared on every lockout state change
// [R9] Sync falling edges replace oscillator when present
// [R10] Ramp cut by sync counts as undervoltage
module undervoltage_cycle_qualifier (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Oscillator and sync
    input wire logic oscTick,
    input wire logic syncIn,
    // Analog comparator: ramp reached 90%
    input wire logic rampDone,
    // Outputs
    output logic rampStart,
    output logic powerGood,
    output logic softStartRelease,
    output logic pwmEnable,
    output logic gateDrivesOff,
    output logic undervoltageLockout,
    output logic [ucq_pkg::QUAL_WIDTH-1:0] qualCount
);
    logic cycleStart;
    logic rampSeen_r;
    logic goodCycle;
    ucq_pkg::ucq_state_t state_r;
    ucq_pkg::ucq_state_t state_nxt;
    logic [ucq_pkg::QUAL_WIDTH-1:0] count_r;
    logic [ucq_pkg::QUAL_WIDTH-1:0] count_nxt;

    ucq_edge_select edgeSel (
        .ref_clk(ref_clk),
        .rst(rst),
        .oscTick(oscTick),
        .syncIn(syncIn),
        .cycleStart(cycleStart)
    );

    // Ramp completion latched within the current period
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rampSeen_r <= 1'b0;
        end else if (cycleStart) begin
            rampSeen_r <= 1'b0; // [R1]
        end else if (rampDone) begin
            rampSeen_r <= 1'b1;
        end
    end

    // A sync edge that cuts the ramp short looks the same: not yet done
    assign goodCycle = rampSeen_r || rampDone; // [R2] [R10]

    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        if (cycleStart) begin
            unique case (state_r)
                ucq_pkg::ST_LOCKED: begin
                    if (!goodCycle) begin
                        count_nxt = ucq_pkg::QUAL_ZERO; // [R4]
                    end else if (count_r == ucq_pkg::QUAL_COUNT - ucq_pkg::QUAL_ONE) begin
                        state_nxt = ucq_pkg::ST_RUNNING; // [R5]
                        count_nxt = ucq_pkg::QUAL_ZERO; // [R8]
                    end else begin
                        count_nxt = count_r + ucq_pkg::QUAL_ONE; // [R4]
                    end
                end
                ucq_pkg::ST_RUNNING: begin
                    if (goodCycle) begin
                        count_nxt = ucq_pkg::QUAL_ZERO; // [R4]
                    end else if (count_r == ucq_pkg::QUAL_COUNT - ucq_pkg::QUAL_ONE) begin
                        state_nxt = ucq_pkg::ST_LOCKED; // [R6] [R10]
                        count_nxt = ucq_pkg::QUAL_ZERO; // [R8]
                    end else begin
                        count_nxt = count_r + ucq_pkg::QUAL_ONE; // [R6]
                    end
                end
                default: begin
                    state_nxt = ucq_pkg::ST_LOCKED;
                    count_nxt = ucq_pkg::QUAL_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ucq_pkg::ST_LOCKED;
            count_r <= ucq_pkg::QUAL_ZERO;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rampStart <= 1'b0;
        end else begin
            rampStart <= cycleStart; // [R1]
        end
    end

    // Drives stay off for one clock after release, PWM gets it at the next good master clock cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            powerGood <= 1'b0;
            softStartRelease <= 1'b0;
            undervoltageLockout <= 1'b1;
            gateDrivesOff <= 1'b1;
            pwmEnable <= 1'b0;
            qualCount <= ucq_pkg::QUAL_ZERO;
        end else begin
            powerGood <= (state_nxt == ucq_pkg::ST_RUNNING); // [R5]
            softStartRelease <= (state_nxt == ucq_pkg::ST_RUNNING); // [R7]
            undervoltageLockout <= (state_nxt == ucq_pkg::ST_LOCKED); // [R6]
            gateDrivesOff <= (state_nxt == ucq_pkg::ST_LOCKED) || !softStartRelease; // [R5]
            if (state_nxt == ucq_pkg::ST_LOCKED) begin
                pwmEnable <= 1'b0; // [R3]
            end else if (cycleStart) begin
                pwmEnable <= goodCycle && softStartRelease; // [R3]
            end
            qualCount <= count_nxt;
        end
    end
endmodule
`default_nettype wire

// *** testbench/ucq_ramp_model.sv ***
// Oscillator and ramp comparator model
`timescale 1ns/1ns
`default_nettype none
module ucq_ramp_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Ramp control
    input wire logic rampStart,
    input wire logic [4:0] rampLen,
    // Comparator side
    output logic oscTick,
    output logic rampDone
);
    logic [4:0] per, cnt, len;
    always_ff @(posedge ref_clk) begin
        per <= (rst || per == 5'h09) ? 5'h00 : per + 5'h01;
        oscTick <= !rst && per == 5'h09;
        // Length latched at ramp start so a change lands on the next ramp
        if (rst || rampStart) begin
            cnt <= 5'h00;
            len <= rst ? 5'h1F : rampLen;
        end else if (cnt != 5'h1F) begin
            cnt <= cnt + 5'h01;
        end
        // Widened so a ramp parked at the top count cannot wrap back to not-done
        rampDone <= !rst && !rampStart && ({1'b0, cnt} + 6'h01 >= {1'b0, len});
    end
endmodule
`default_nettype wire

// *** testbench/ucq_props.sv ***
// Port assertions for the qualifier
`timescale 1ns/1ns
`default_nettype none
module ucq_props (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Observed outputs
    input wire logic rampStart,
    input wire logic powerGood,
    input wire logic softStartRelease,
    input wire logic pwmEnable,
    input wire logic gateDrivesOff,
    input wire logic undervoltageLockout,
    input wire logic [ucq_pkg::QUAL_WIDTH-1:0] qualCount
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    ss_follows_a: assert property (softStartRelease == powerGood) else $error("ss");
    lock_inv_a: assert property (undervoltageLockout != powerGood) else $error("lk");
    pwm_lock_a: assert property (!powerGood |-> !pwmEnable) else $error("pwm");
    drv_off_a: assert property (!powerGood |-> gateDrivesOff) else $error("drv");
    drv_rel_a: assert property ($rose(powerGood) |-> gateDrivesOff ##1 !gateDrivesOff)
        else $error("rel");
    run_in_a: assert property ($rose(powerGood) |-> $past(qualCount) == 3'h6)
        else $error("run");
    lock_in_a: assert property ($fell(powerGood) |-> $past(qualCount) == 3'h6)
        else $error("lock");
    cnt_clr_a: assert property ($changed(powerGood) |-> qualCount == 3'h0)
        else $error("clr");
    cnt_step_a: assert property ($changed(qualCount) |->
        qualCount == 3'h0 || qualCount == $past(qualCount) + 3'h1) else $error("step");
    ramp_pulse_a: assert property (rampStart |=> !rampStart) else $error("ramp");
    cover property ($rose(powerGood));
    cover property ($fell(powerGood));
    cover property ($rose(pwmEnable));
endmodule
bind undervoltage_cycle_qualifier ucq_props u_props (.ref_clk, .rst, .rampStart, .powerGood,
    .softStartRelease, .pwmEnable, .gateDrivesOff, .undervoltageLockout, .qualCount);
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the qualifier
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0, rst = 1'b1, syncIn = 1'b0, oscTick, rampDone, rampStart;
    logic powerGood, softStartRelease, pwmEnable, gateDrivesOff, undervoltageLockout;
    logic [2:0] qualCount;
    logic [4:0] rampLen = 5'h03;
    int n_mismatch = 0, tests_run = 0;
    int lens [8] = '{3, 20, 3, 20, 20, 3, 3, 3};
    int nt [8] = '{10, 6, 3, 6, 3, 7, 1, 1};
    logic [1:0] ex [8] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h0, 2'h0, 2'h2, 2'h3};
    undervoltage_cycle_qualifier DUT (.ref_clk, .rst, .oscTick, .syncIn, .rampDone,
        .rampStart, .powerGood, .softStartRelease, .pwmEnable, .gateDrivesOff,
        .undervoltageLockout, .qualCount);
    ucq_ramp_model u_far (.ref_clk, .rst, .rampStart, .rampLen, .oscTick, .rampDone);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic chk(string nm, logic [2:0] e, logic [2:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic run(int n);
        int k;
        repeat (n) begin
            for (k = 0; oscTick !== 1'b1 && k < 30; k++) @(posedge ref_clk);
            if (k == 30) begin
                n_mismatch++;
                wrap_up();
            end
            repeat (4) @(posedge ref_clk);
        end
    endtask
    // Sync period 6 against a free-run period of 10
    task automatic sync(int n);
        repeat (n) begin
            syncIn <= 1'b1;
            repeat (3) @(posedge ref_clk);
            syncIn <= 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rampLen <= 5'(lens[i]);
            run(nt[i]);
            chk("pg", {2'h0, ex[i][1]}, {2'h0, powerGood});
            chk("pwm", {2'h0, ex[i][0]}, {2'h0, pwmEnable});
            chk("drv", {2'h0, !ex[i][1]}, {2'h0, gateDrivesOff});
            chk("ss", {2'h0, ex[i][1]}, {2'h0, softStartRelease});
            chk("lk", {2'h0, !ex[i][1]}, {2'h0, undervoltageLockout});
            $display("row %0d done", i);
        end
        rampLen <= 5'h07;
        sync(10);
        chk("cut", 3'h0, {2'h0, powerGood});
        rampLen <= 5'h02;
        sync(10);
        chk("sync", 3'h1, {2'h0, powerGood});
        $display("sync done");
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("rpg", 3'h0, {2'h0, powerGood});
        chk("rcnt", 3'h0, qualCount);
        chk("rlk", 3'h1, {2'h0, undervoltageLockout});
        chk("rramp", 3'h0, {2'h0, rampStart});
        chk("rss", 3'h0, {2'h0, softStartRelease});
        $display("reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
